// File: rtl/burst_sram_pkg.sv
package burst_sram_pkg;
    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W    = 15;
    localparam int DATA_W    = 32;
    localparam int LANES     = 4;
    localparam int LANE_W    = 8;
    localparam int WORDS     = 32768;
    localparam int BURST_W   = 2;
    localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
    localparam logic [LANES-1:0]   LANES_ALL = 4'hf;
    localparam logic [LANES-1:0]   LANES_NONE = 4'h0;

    // ------------------------------------------------------------
    // Cycle state along the usual path
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b11
    } cycle_e;
endpackage

// File: rtl/pipelined_burst_sram_control.sv
`timescale 1ns/1ps
module pipelined_burst_sram_control (
    input  wire logic                              clk_sys,
    input  wire logic                              reset,
    input  wire logic [burst_sram_pkg::ADDR_W-1:0] address_inputs,
    input  wire logic                              primary_chip_enable_n,
    input  wire logic                              depth_enable_high,
    input  wire logic                              depth_enable_low_n,
    input  wire logic                              processor_addr_strobe_n,
    input  wire logic                              controller_addr_strobe_n,
    input  wire logic                              burst_advance_n,
    input  wire logic                              global_write_n,
    input  wire logic                              byte_write_gate_n,
    input  wire logic [burst_sram_pkg::LANES-1:0]  byte_lane_write_n,
    input  wire logic                              output_enable_n,
    input  wire logic                              burst_order_select,
    input  wire logic                              sleep_request,
    input  wire logic [burst_sram_pkg::DATA_W-1:0] data_lanes_in,
    output logic      [burst_sram_pkg::DATA_W-1:0] data_lanes_out,
    output logic      [burst_sram_pkg::LANES-1:0]  data_lanes_oe,
    output logic                                   sleep_active
);
    import burst_sram_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Next burst address bits from start, current offset count
    function automatic logic [BURST_W-1:0] burst_bits(
        input logic [BURST_W-1:0] start,
        input logic [BURST_W-1:0] count,
        input logic               interleave
    );
        if (interleave)
            burst_bits = start ^ count;
        else
            burst_bits = start + count;
    endfunction

    // ------------------------------------------------------------
    // Synchronised asynchronous pins
    // ------------------------------------------------------------
    logic sleep_s1_r;
    logic sleep_s2_r;
    logic order_s1_r;
    logic order_s2_r;

    // Sleep and order pins are not clocked by the far side
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sleep_s1_r <= 1'b0;
            sleep_s2_r <= 1'b0;
            order_s1_r <= 1'b0;
            order_s2_r <= 1'b0;
        end else begin
            sleep_s1_r <= sleep_request;
            sleep_s2_r <= sleep_s1_r;
            order_s1_r <= burst_order_select;
            order_s2_r <= order_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------
    logic enables_on;
    logic write_req;
    logic [LANES-1:0] lanes_req;
    logic start_proc;
    logic start_ctrl;
    logic deselect;
    logic cont;

    // Decode of the sampled control inputs
    always_comb begin
        enables_on = !primary_chip_enable_n && depth_enable_high
                     && !depth_enable_low_n;
        // Global write wins over gate and lanes
        if (!global_write_n)
            lanes_req = LANES_ALL;
        else if (!byte_write_gate_n)
            lanes_req = ~byte_lane_write_n;
        else
            lanes_req = LANES_NONE;
        write_req  = (lanes_req != LANES_NONE);
        start_proc = !processor_addr_strobe_n && enables_on;
        start_ctrl = processor_addr_strobe_n
                     && !controller_addr_strobe_n && enables_on;
        deselect   = (primary_chip_enable_n
                      && !controller_addr_strobe_n)
                     || (!processor_addr_strobe_n
                         && !primary_chip_enable_n && !enables_on)
                     || (processor_addr_strobe_n
                         && !controller_addr_strobe_n && !enables_on);
        cont       = controller_addr_strobe_n
                     && (processor_addr_strobe_n
                         || primary_chip_enable_n);
    end

    // ------------------------------------------------------------
    // Cycle state and burst address
    // ------------------------------------------------------------
    cycle_e                    state_r;
    logic [ADDR_W-1:0]         base_r;
    logic [BURST_W-1:0]        count_r;
    logic [LANES-1:0]          lanes_r;
    logic [DATA_W-1:0]         wdata_r;
    logic [ADDR_W-1:0]         cur_addr;

    // Upper bits stay at the registered start for the whole burst
    assign cur_addr = {base_r[ADDR_W-1:BURST_W],
                       burst_bits(base_r[BURST_W-1:0], count_r,
                                  order_s2_r)};

    // Sleep parks the sequencer; only a new start wakes it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= ST_IDLE;
            base_r  <= '0;
            count_r <= BURST_RST;
            lanes_r <= LANES_NONE;
        end else if (sleep_s2_r) begin
            state_r <= ST_IDLE;
            lanes_r <= LANES_NONE;
        end else if (start_proc) begin
            state_r <= ST_READ;
            base_r  <= address_inputs;
            count_r <= BURST_RST;
            lanes_r <= LANES_NONE;
        end else if (start_ctrl) begin
            state_r <= write_req ? ST_WRITE : ST_READ;
            base_r  <= address_inputs;
            count_r <= BURST_RST;
            lanes_r <= lanes_req;
        end else if (deselect) begin
            state_r <= ST_IDLE;
            lanes_r <= LANES_NONE;
        end else if (cont && state_r != ST_IDLE) begin
            // Continue or suspend takes the cycle type from the current write inputs
            state_r <= write_req ? ST_WRITE : ST_READ;
            lanes_r <= lanes_req;
            // High advance leaves the count alone: suspend
            if (!burst_advance_n)
                count_r <= count_r + 2'h1;
        end else begin
            lanes_r <= LANES_NONE;
        end
    end

    // Write data captured every edge; used only with lanes set
    always_ff @(posedge clk_sys) begin
        if (reset)
            wdata_r <= '0;
        else
            wdata_r <= data_lanes_in;
    end

    // ------------------------------------------------------------
    // Array and output pipeline
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [WORDS];
    logic [DATA_W-1:0] rdata_r;
    logic              rvalid_r;

    // Self-timed array write, all selected byte lanes on the same edge; suspend
    // repeats the write at the held address
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < LANES; i++) begin
            if (state_r == ST_WRITE && lanes_r[i] && !sleep_s2_r)
                mem[cur_addr][i*LANE_W +: LANE_W]
                    <= wdata_r[i*LANE_W +: LANE_W];
        end
    end

    // Read data waits in the output register one edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= mem[cur_addr];
            rvalid_r <= (state_r == ST_READ) && !sleep_s2_r;
        end
    end

    // Output enable gates drive combinationally, no sampling
    assign data_lanes_out = rdata_r;
    assign data_lanes_oe  = (rvalid_r && !output_enable_n
                             && !sleep_s2_r)
                            ? LANES_ALL : LANES_NONE;
    assign sleep_active   = sleep_s2_r && (state_r == ST_IDLE);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_GLOBAL_ALL:
    assert property (@(posedge clk_sys) disable iff (reset)
        start_ctrl && !global_write_n && !sleep_s2_r
        |=> state_r == ST_WRITE && lanes_r == LANES_ALL)
        else $error("global write did not select all lanes");

    AST_GATE_LANES:
    assert property (@(posedge clk_sys) disable iff (reset)
        start_ctrl && global_write_n && !byte_write_gate_n && !sleep_s2_r
        |=> lanes_r == ~$past(byte_lane_write_n))
        else $error("byte lanes not taken from lane inputs");

    AST_PROC_READ:
    assert property (@(posedge clk_sys) disable iff (reset)
        start_proc && !sleep_s2_r |=> state_r == ST_READ)
        else $error("processor strobe start was not a read");

    AST_BLOCKED:
    assert property (@(posedge clk_sys) disable iff (reset)
        primary_chip_enable_n && !controller_addr_strobe_n
        |=> state_r == ST_IDLE)
        else $error("primary enable high did not deselect");

    AST_DEPTH:
    assert property (@(posedge clk_sys) disable iff (reset)
        !primary_chip_enable_n && !processor_addr_strobe_n
        && !(depth_enable_high && !depth_enable_low_n)
        |=> state_r == ST_IDLE)
        else $error("depth enable off still started a cycle");

    AST_SUSPEND:
    assert property (@(posedge clk_sys) disable iff (reset)
        cont && burst_advance_n && !sleep_s2_r |=> $stable(count_r))
        else $error("suspend moved the burst address");

    AST_ADVANCE:
    assert property (@(posedge clk_sys) disable iff (reset)
        cont && !burst_advance_n && state_r != ST_IDLE && !sleep_s2_r
        |=> count_r == $past(count_r) + 2'h1)
        else $error("advance did not step the burst");

    AST_UPPER:
    assert property (@(posedge clk_sys) disable iff (reset)
        !start_proc && !start_ctrl |=> $stable(base_r))
        else $error("upper address changed inside a burst");

    AST_NO_DRIVE_WRITE:
    assert property (@(posedge clk_sys) disable iff (reset)
        state_r == ST_WRITE ##1 state_r == ST_WRITE
        |-> data_lanes_oe == LANES_NONE)
        else $error("lanes driven during a write");

    AST_LATENCY:
    assert property (@(posedge clk_sys) disable iff (reset)
        state_r == ST_READ && !sleep_s2_r && !output_enable_n
        ##1 !output_enable_n && !sleep_s2_r
        |-> data_lanes_oe == LANES_ALL)
        else $error("read data not presented one cycle later");

    AST_SLEEP:
    assert property (@(posedge clk_sys) disable iff (reset)
        sleep_s2_r |=> state_r == ST_IDLE && data_lanes_oe == LANES_NONE)
        else $error("sleep did not park the block");
endmodule

// File: dv/cache_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side pin encoder
// ------------------------------------------------------------
// Idle goes out as a deselect: both strobes high would suspend
// and repeat the last beat instead of resting
module cache_host_model (
    input  wire logic       clk_sys,
    input  wire logic [2:0] cmd,
    input  wire logic [1:0] kind,
    input  wire logic [3:0] lanes,
    input  wire logic       rd_oe_n,
    input  wire logic       ce1_n,
    output logic            primary_chip_enable_n,
    output logic            processor_addr_strobe_n,
    output logic            controller_addr_strobe_n,
    output logic            burst_advance_n,
    output logic            global_write_n,
    output logic            byte_write_gate_n,
    output logic [3:0]      byte_lane_write_n,
    output logic            output_enable_n
);
    logic wr;
    logic wr_r;
    // Strobes from the command code
    assign primary_chip_enable_n    = ce1_n | (cmd == 3'h0);
    assign processor_addr_strobe_n  = cmd != 3'h1;
    assign controller_addr_strobe_n = (cmd != 3'h0) && (cmd != 3'h2);
    assign burst_advance_n          = cmd != 3'h3;
    // Lane-only writes keep global high and the gate low
    assign global_write_n    = kind != 2'h1;
    assign byte_write_gate_n = kind != 2'h2;
    assign byte_lane_write_n = (kind == 2'h2) ? ~lanes : 4'hf;
    // Enable held off across a write and the cycle after it
    assign wr = (kind == 2'h1) || ((kind == 2'h2) && (lanes != 4'h0));
    assign output_enable_n = rd_oe_n | wr | wr_r;
    always_ff @(posedge clk_sys) begin
        wr_r <= wr;
    end
endmodule

// File: dv/pipelined_burst_sram_control_bench.sv
`timescale 1ns/1ps
module pipelined_burst_sram_control_bench;
    import burst_sram_pkg::*;
    logic              clk_sys = 1'b0;
    logic              reset = 1'b1;
    logic [ADDR_W-1:0] address_inputs = '0;
    logic [DATA_W-1:0] data_lanes_in = '0;
    logic [2:0]        cmd = 3'h0;
    logic [1:0]        kind = 2'h0;
    logic [3:0]        lanes = 4'h0;
    logic              rd_oe_n = 1'b0;
    logic              ce1_n = 1'b0;
    logic              depth_enable_high = 1'b1;
    logic              depth_enable_low_n = 1'b0;
    logic              burst_order_select = 1'b0;
    logic              sleep_request = 1'b0;
    logic primary_chip_enable_n, processor_addr_strobe_n;
    logic controller_addr_strobe_n, burst_advance_n, global_write_n;
    logic byte_write_gate_n, output_enable_n, sleep_active;
    logic [LANES-1:0]  byte_lane_write_n, data_lanes_oe;
    logic [DATA_W-1:0] data_lanes_out, mem [int], expq [$];
    logic [ADDR_W-1:0] cur, base;
    logic [1:0]        st0, cnt;
    logic [31:0]       seed = 32'h6fcb;
    bit                act, isw, il, zz;
    int                failures, check_count, i;

    cache_host_model host_u (.clk_sys, .cmd, .kind, .lanes, .rd_oe_n,
        .ce1_n, .primary_chip_enable_n, .processor_addr_strobe_n,
        .controller_addr_strobe_n, .burst_advance_n, .global_write_n,
        .byte_write_gate_n, .byte_lane_write_n, .output_enable_n);
    pipelined_burst_sram_control dut_u (.clk_sys, .reset, .address_inputs,
        .primary_chip_enable_n, .depth_enable_high, .depth_enable_low_n,
        .processor_addr_strobe_n, .controller_addr_strobe_n,
        .burst_advance_n, .global_write_n, .byte_write_gate_n,
        .byte_lane_write_n, .output_enable_n, .burst_order_select,
        .sleep_request, .data_lanes_in, .data_lanes_out, .data_lanes_oe,
        .sleep_active);

    always #2 clk_sys = ~clk_sys;

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic cmp_w(input string n, input logic [DATA_W-1:0] e, g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cmp_f(input string n, input logic [3:0] e, g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // Drive one cycle and predict it; 0 idle, 1/2 starts, 3 step, 4 hold
    task automatic op(input [2:0] c, input [1:0] k, input [3:0] ln,
                      input [ADDR_W-1:0] a, input [DATA_W-1:0] d);
        logic w;
        @(posedge clk_sys);
        #1;
        cmd = c;
        kind = k;
        lanes = ln;
        address_inputs = a;
        data_lanes_in = d;
        w = (k == 1) || (k == 2 && ln != 0);
        if (zz || c == 0) begin
            act = 0;
        end else if (c <= 2) begin
            act = !ce1_n && depth_enable_high && !depth_enable_low_n;
            isw = (c == 2) && w;
            cur = a;
            st0 = a[1:0];
            cnt = 0;
        end else if (act) begin
            isw = w;
            cnt = cnt + (c == 3);
            cur[1:0] = il ? st0 ^ cnt : st0 + cnt;
        end
        if (act && isw) begin
            if (!mem.exists(cur)) mem[cur] = '0;
            for (int j = 0; j < LANES; j++) begin
                if (k == 1 || ln[j])
                    mem[cur][j*LANE_W +: LANE_W] = d[j*LANE_W +: LANE_W];
            end
        end else if (act && !rd_oe_n) begin
            expq.push_back(mem[cur]);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) op(0, 0, 0, 0, 0);
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Each driven beat takes the oldest expected word
    always @(posedge clk_sys) begin
        #2;
        if (data_lanes_oe !== 4'h0) begin
            if (expq.size() == 0) begin
                cmp_f("stray drive", 4'h0, data_lanes_oe);
            end else begin
                cmp_f("drive", LANES_ALL, data_lanes_oe);
                cmp_w("read", expq.pop_front(), data_lanes_out);
            end
        end
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        #1 reset = 1'b0;
        base = ADDR_W'(rnd());
        base[1:0] = 2'b01;
        // Global write burst wraps from a start of 01
        op(2, 1, 0, base, rnd());
        repeat (3) op(3, 1, 0, base, rnd());
        // Lane writes back to back; the fifth selects none and reads
        for (i = 0; i < 5; i++) op(2, 2, 4'(1 << i), base, rnd());
        idle(3);
        // Linear read with a held beat, output enable pulsed mid-burst
        op(1, 0, 0, base, 0);
        op(3, 0, 0, base, 0);
        op(4, 0, 0, base, 0);
        op(3, 0, 0, base, 0);
        #2 rd_oe_n = 1'b1;
        #0.5 cmp_f("async oe", 4'h0, data_lanes_oe);
        rd_oe_n = 1'b0;
        repeat (2) op(3, 0, 0, base, 0);
        // Interleaved order waits out the synchroniser
        burst_order_select = 1'b1;
        il = 1'b1;
        idle(3);
        op(2, 0, 0, base, 0);
        repeat (3) op(3, 0, 0, base, 0);
        idle(3);
        // Each deselect case floats, and a step from idle does nothing
        for (i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            #1;
            ce1_n = (i == 0);
            depth_enable_high = (i != 1);
            depth_enable_low_n = (i == 2);
            op((i == 1) ? 3'h1 : 3'h2, 0, 0, base, 0);
            op(3, 0, 0, base, 0);
        end
        @(posedge clk_sys);
        #1;
        {ce1_n, depth_enable_high, depth_enable_low_n, rd_oe_n} = 4'h5;
        // Reads with output enable high stay floating
        op(1, 0, 0, base, 0);
        op(3, 0, 0, base, 0);
        idle(3);
        rd_oe_n = 1'b0;
        // Sleep refuses a start; the array survives it
        sleep_request = 1'b1;
        // Look a little after each edge, never in the launching step
        for (i = 0; i < 8 && sleep_active !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (i == 8) begin
            failures++;
        end else begin
            cmp_f("sleep", 4'h1, {3'h0, sleep_active});
            zz = 1'b1;
            op(1, 0, 0, base, 0);
            idle(2);
            sleep_request = 1'b0;
            idle(3);
            zz = 1'b0;
            op(1, 0, 0, base, 0);
            repeat (2) op(3, 0, 0, base, 0);
            idle(4);
            cmp_w("pending", '0, DATA_W'(expq.size()));
        end
        finish_test();
    end
endmodule
